// >>> src/branch_unit_pkg.sv
// constants, field layout and branch kinds for the copro/equal branch unit
// Notes on behaviour
// - target is sign-extended offset shifted left two plus delay-slot address
// - copro-true branch uses flag sampled in previous instruction; taken after one slot
// - likely copro-true with false flag nullifies the delay-slot instruction
// - likely copro-false branches on false flag, nullifies slot on true flag
// - copro-false branch taken after one slot when sampled flag is false
// - every coprocessor-conditional branch can raise coprocessor unusable
// - copro-true decode: 0100zz, sub-opcode 01000, condition 00001
// - likely copro-true decode: copro group, sub-opcode 01000, condition 00011
// - likely copro-false decode: copro group, sub-opcode 01000, condition 00010
// - equal branch decode: opcode 000100, rs, rt, 16-bit offset
// - equal branch compares full registers, taken after one slot when equal
package branch_unit_pkg;
    localparam int XLEN       = 32;
    localparam int OFF_W      = 16;
    localparam int IDX_W      = 5;
    localparam int NUM_UNITS  = 4;
    localparam int UNIT_W     = 2;
    localparam int TARGET_SHIFT = 2;
    localparam int EXT_W      = XLEN - OFF_W - TARGET_SHIFT;

    // instruction field positions
    localparam int OPC_HI     = 31;
    localparam int OPC_LO     = 26;
    localparam int PREFIX_LO  = 28;
    localparam int UNIT_HI    = 27;
    localparam int RS_HI      = 25;
    localparam int RS_LO      = 21;
    localparam int RT_HI      = 20;
    localparam int RT_LO      = 16;
    localparam int OFF_HI     = 15;

    // encodings
    localparam logic [5:0] OPC_EQUAL          = 6'h04;
    localparam logic [3:0] OPC_COPRO_PREFIX   = 4'h4;
    localparam logic [4:0] SUB_BRANCH         = 5'h08;
    localparam logic [4:0] COND_FALSE         = 5'h00;
    localparam logic [4:0] COND_TRUE          = 5'h01;
    localparam logic [4:0] COND_FALSE_LIKELY  = 5'h02;
    localparam logic [4:0] COND_TRUE_LIKELY   = 5'h03;

    localparam logic [XLEN-1:0] SLOT_STEP     = 32'h0000_0004;

    typedef enum logic [5:0] {
        KIND_NONE      = 6'b000001,
        KIND_CT        = 6'b000010,
        KIND_CTL       = 6'b000100,
        KIND_CF        = 6'b001000,
        KIND_CFL       = 6'b010000,
        KIND_EQUAL     = 6'b100000
    } branch_kind_e;
endpackage

// >>> src/copro_and_equal_branch_unit.sv
// decode and resolution of coprocessor-conditional and equal-compare branches
module copro_and_equal_branch_unit #(
    parameter int UNITS = branch_unit_pkg::NUM_UNITS
) (
    input  wire logic                                  clk_i,
    input  wire logic                                  rst_i,
    input  wire logic                                  instr_valid_i,
    input  wire logic [branch_unit_pkg::XLEN-1:0]      instr_i,
    input  wire logic [branch_unit_pkg::XLEN-1:0]      pc_i,
    input  wire logic [UNITS-1:0]                      coprocessor_condition_input_i,
    input  wire logic [UNITS-1:0]                      copro_usable_i,
    input  wire logic [branch_unit_pkg::XLEN-1:0]      rs_data_i,
    input  wire logic [branch_unit_pkg::XLEN-1:0]      rt_data_i,
    output logic      [branch_unit_pkg::IDX_W-1:0]     rs_index_o,
    output logic      [branch_unit_pkg::IDX_W-1:0]     rt_index_o,
    output logic                                       redirect_o,
    output logic      [branch_unit_pkg::XLEN-1:0]      redirect_target_o,
    output logic                                       nullify_slot_o,
    output logic                                       copro_unusable_o,
    output logic      [branch_unit_pkg::UNIT_W-1:0]    unusable_unit_o
);
    import branch_unit_pkg::*;

    logic [UNITS-1:0]   coprocessor_condition_bits;
    branch_kind_e       kind;
    logic               next_taken;
    logic               next_likely;
    logic               next_copro;

    // flags as seen while the preceding instruction executed
    copro_condition_sampler #(
        .UNITS                          (UNITS)
    ) u_sampler (
        .clk_i                          (clk_i),
        .rst_i                          (rst_i),
        .instr_valid_i                  (instr_valid_i),
        .coprocessor_condition_input_i  (coprocessor_condition_input_i),
        .coprocessor_condition_bits_o   (coprocessor_condition_bits)
    );

    // instruction fields
    wire [5:0]        opcode     = instr_i[OPC_HI:OPC_LO];
    wire [3:0]        prefix     = instr_i[OPC_HI:PREFIX_LO];
    wire [UNIT_W-1:0] unit       = instr_i[UNIT_HI:OPC_LO];
    wire [4:0]        sub_opcode = instr_i[RS_HI:RS_LO];
    wire [4:0]        cond_field = instr_i[RT_HI:RT_LO];
    wire [OFF_W-1:0]  offset     = instr_i[OFF_HI:0];

    // register indices go straight to the register file read ports
    assign rs_index_o = instr_i[RS_HI:RS_LO];
    assign rt_index_o = instr_i[RT_HI:RT_LO];

    // coprocessor branch group: 0100zz with sub-opcode 01000
    wire copro_group = (prefix == OPC_COPRO_PREFIX) && (sub_opcode == SUB_BRANCH);

    // kind decode; unknown condition codes fall to none and leave the pc alone
    assign kind = !instr_valid_i                             ? KIND_NONE  :
                  (opcode == OPC_EQUAL)                      ? KIND_EQUAL :
                  !copro_group                               ? KIND_NONE  :
                  (cond_field == COND_TRUE)                  ? KIND_CT    :
                  (cond_field == COND_TRUE_LIKELY)           ? KIND_CTL   :
                  (cond_field == COND_FALSE_LIKELY)          ? KIND_CFL   :
                  (cond_field == COND_FALSE)                 ? KIND_CF    :
                                                               KIND_NONE;

    // target = delay-slot address plus shifted, sign-extended offset
    wire [XLEN-1:0] offset_ext  = {{EXT_W{offset[OFF_W-1]}}, offset, {TARGET_SHIFT{1'b0}}};
    wire [XLEN-1:0] slot_pc     = pc_i + SLOT_STEP;
    wire [XLEN-1:0] next_target = slot_pc + offset_ext;

    wire flag_now    = coprocessor_condition_bits[unit];
    wire unit_usable = copro_usable_i[unit];
    // full-width compare, no sign or partial tricks
    wire regs_equal  = (rs_data_i == rt_data_i);

    // branch condition and likely flag per kind
    always_comb begin
        next_taken  = 1'b0;
        next_likely = 1'b0;
        next_copro  = 1'b0;
        unique case (kind)
            KIND_NONE: begin
                next_taken = 1'b0;
            end
            KIND_CT: begin
                next_taken = flag_now;
                next_copro = 1'b1;
            end
            KIND_CTL: begin
                next_taken  = flag_now;
                next_likely = 1'b1;
                next_copro  = 1'b1;
            end
            KIND_CF: begin
                next_taken = !flag_now;
                next_copro = 1'b1;
            end
            KIND_CFL: begin
                next_taken  = !flag_now;
                next_likely = 1'b1;
                next_copro  = 1'b1;
            end
            KIND_EQUAL: begin
                next_taken = regs_equal;
            end
        endcase
    end

    // an unusable coprocessor turns the branch into an exception; no redirect follows
    wire fault       = next_copro && !unit_usable;
    wire do_redirect = next_taken && !fault;
    // non-likely kinds never nullify, whatever the outcome
    wire do_nullify  = next_likely && !next_taken && !fault;

    // resolution lands one cycle later, while the delay slot is in execute
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            redirect_o        <= 1'b0;
            redirect_target_o <= '0;
            nullify_slot_o    <= 1'b0;
            copro_unusable_o  <= 1'b0;
            unusable_unit_o   <= '0;
        end else begin
            redirect_o        <= do_redirect;
            redirect_target_o <= next_target;
            nullify_slot_o    <= do_nullify;
            copro_unusable_o  <= fault;
            unusable_unit_o   <= unit;
        end
    end

    // checks
    wire copro_kind = (kind == KIND_CT) || (kind == KIND_CTL) ||
                      (kind == KIND_CF) || (kind == KIND_CFL);

    a_target_form: assert property (@(posedge clk_i) disable iff (rst_i)
        (kind != KIND_NONE) |=>
            redirect_target_o == $past(pc_i) + SLOT_STEP + $past(offset_ext))
        else $error("branch target not slot address plus offset");

    a_true_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_CT) && unit_usable |=>
            (redirect_o == $past(flag_now)) && !nullify_slot_o)
        else $error("copro-true branch outcome wrong");

    a_true_likely_null: assert property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_CTL) && unit_usable && !flag_now |=> nullify_slot_o && !redirect_o)
        else $error("likely copro-true did not nullify slot");

    a_false_likely: assert property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_CFL) && unit_usable |=>
            (redirect_o != $past(flag_now)) && (nullify_slot_o == $past(flag_now)))
        else $error("likely copro-false outcome wrong");

    a_false_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_CF) && unit_usable |=> redirect_o != $past(flag_now))
        else $error("copro-false branch outcome wrong");

    a_unusable_raise: assert property (@(posedge clk_i) disable iff (rst_i)
        copro_kind && !unit_usable |=>
            copro_unusable_o && !redirect_o && (unusable_unit_o == $past(unit)))
        else $error("coprocessor unusable not raised");

    a_true_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        instr_valid_i && (instr_i[OPC_HI:PREFIX_LO] == OPC_COPRO_PREFIX) &&
        (instr_i[RS_HI:RS_LO] == SUB_BRANCH) && (instr_i[RT_HI:RT_LO] == COND_TRUE)
            |-> kind == KIND_CT)
        else $error("copro-true encoding not decoded");

    a_true_likely_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        instr_valid_i && (instr_i[OPC_HI:PREFIX_LO] == OPC_COPRO_PREFIX) &&
        (instr_i[RS_HI:RS_LO] == SUB_BRANCH) && (instr_i[RT_HI:RT_LO] == COND_TRUE_LIKELY)
            |-> kind == KIND_CTL)
        else $error("likely copro-true encoding not decoded");

    a_false_likely_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        instr_valid_i && (instr_i[OPC_HI:PREFIX_LO] == OPC_COPRO_PREFIX) &&
        (instr_i[RS_HI:RS_LO] == SUB_BRANCH) && (instr_i[RT_HI:RT_LO] == COND_FALSE_LIKELY)
            |-> kind == KIND_CFL)
        else $error("likely copro-false encoding not decoded");

    a_equal_decode: assert property (@(posedge clk_i) disable iff (rst_i)
        instr_valid_i && (instr_i[OPC_HI:OPC_LO] == OPC_EQUAL) |->
            (kind == KIND_EQUAL) && (rs_index_o == instr_i[RS_HI:RS_LO]) &&
            (rt_index_o == instr_i[RT_HI:RT_LO]))
        else $error("equal branch not decoded");

    a_equal_taken: assert property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_EQUAL) |=>
            (redirect_o == ($past(rs_data_i) == $past(rt_data_i))) && !nullify_slot_o)
        else $error("equal branch outcome wrong");

    a_slot_kept: assert property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_CT) || (kind == KIND_CF) || (kind == KIND_EQUAL) || (kind == KIND_NONE)
            |=> !nullify_slot_o)
        else $error("non-likely branch nullified its slot");

    c_equal_taken: cover property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_EQUAL) ##1 redirect_o);
    c_likely_nullify: cover property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_CFL) ##1 nullify_slot_o);
    c_true_taken: cover property (@(posedge clk_i) disable iff (rst_i)
        (kind == KIND_CT) ##1 redirect_o);
    c_unusable: cover property (@(posedge clk_i) disable iff (rst_i)
        copro_kind ##1 copro_unusable_o);
endmodule // copro_and_equal_branch_unit

// >>> src/copro_condition_sampler.sv
// holds each coprocessor condition flag as seen during the last executed instruction
module copro_condition_sampler #(
    parameter int UNITS = branch_unit_pkg::NUM_UNITS
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             instr_valid_i,
    input  wire logic [UNITS-1:0] coprocessor_condition_input_i,
    output logic      [UNITS-1:0] coprocessor_condition_bits_o
);
    import branch_unit_pkg::*;

    // one flop per unit; only instructions that really execute refresh the copy
    genvar u;
    for (u = 0; u < UNITS; u++) begin : g_unit
        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                coprocessor_condition_bits_o[u] <= 1'b0;
            end else if (instr_valid_i) begin
                coprocessor_condition_bits_o[u] <= coprocessor_condition_input_i[u];
            end
        end
    end

    a_flag_sampled: assert property (@(posedge clk_i) disable iff (rst_i)
        instr_valid_i |=> coprocessor_condition_bits_o == $past(coprocessor_condition_input_i))
        else $error("condition copy not taken from previous instruction");
    a_flag_holds: assert property (@(posedge clk_i) disable iff (rst_i)
        !instr_valid_i |=> $stable(coprocessor_condition_bits_o))
        else $error("condition copy changed without an instruction");
endmodule // copro_condition_sampler

// >>> tb/copro_and_equal_branch_unit_tb_top.sv
// self-checking bench for the copro/equal branch unit
`define CHECK(got, want, msg) begin check_count++; if ((got) !== (want)) begin err_total++; $display("mismatch at %0t: %s", $time, msg); end end
module copro_and_equal_branch_unit_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import branch_unit_pkg::*;
    typedef struct packed {logic red; logic [31:0] tgt; logic nul; logic unu; logic [1:0] unit;} note_s;
    logic clk_i = 1'b0, rst_i = 1'b1, instr_valid_i = 1'b0, slow = 1'b0, obs_pending = 1'b0;
    logic [31:0] instr_i = 32'h0, pc_i = 32'h0, rs_data_i = 32'h0, rt_data_i = 32'h0;
    logic [3:0]  flags, copro_usable_i = 4'hF, model_copy = 4'h0;
    logic [4:0]  rs_index_o, rt_index_o;
    logic        redirect_o, nullify_slot_o, copro_unusable_o;
    logic [31:0] redirect_target_o;
    logic [1:0]  unusable_unit_o;
    int          err_total = 0, check_count = 0, cycles = 0, seed = 66;
    note_s       exp_q[$];
    note_s       got;
    copro_and_equal_branch_unit dut (.clk_i(clk_i), .rst_i(rst_i), .instr_valid_i(instr_valid_i),
        .instr_i(instr_i), .pc_i(pc_i), .coprocessor_condition_input_i(flags),
        .copro_usable_i(copro_usable_i), .rs_data_i(rs_data_i), .rt_data_i(rt_data_i),
        .rs_index_o(rs_index_o), .rt_index_o(rt_index_o), .redirect_o(redirect_o),
        .redirect_target_o(redirect_target_o), .nullify_slot_o(nullify_slot_o),
        .copro_unusable_o(copro_unusable_o), .unusable_unit_o(unusable_unit_o));
    copro_flag_source #(.UNITS(NUM_UNITS)) partner (.clk_i(clk_i), .rst_i(rst_i),
        .slow_i(slow), .flags_o(flags));
    always #4 clk_i = ~clk_i;
    // expected outcome worked out from the encoding and the sampled copy
    function automatic note_s predict(logic [31:0] ins, pc, rs, rt, logic [3:0] cp, um);
        note_s n;
        logic  take;
        n = '0;
        n.tgt = pc + SLOT_STEP + {{14{ins[15]}}, ins[15:0], 2'b00};
        if (ins[31:28] == OPC_COPRO_PREFIX && ins[25:21] == SUB_BRANCH && ins[20:18] == 3'h0) begin
            n.unit = ins[27:26];
            take = ins[16] ? cp[n.unit] : !cp[n.unit];
            n.unu = !um[n.unit];
            n.red = um[n.unit] && take;
            n.nul = um[n.unit] && ins[17] && !take;
        end else if (ins[31:26] == OPC_EQUAL) begin
            n.red = (rs === rt);
        end
        return n;
    endfunction
    // one instruction per call; the copy model follows every valid cycle
    task automatic issue(input logic v, input logic [31:0] ins, pc, rs, rt, input logic [3:0] um);
        @(posedge clk_i);
        instr_valid_i <= v;
        instr_i <= ins;
        pc_i <= pc;
        rs_data_i <= rs;
        rt_data_i <= rt;
        copro_usable_i <= um;
        #1;
        `CHECK({rs_index_o, rt_index_o}, ins[25:16], "register index fields")
        if (v) begin
            exp_q.push_back(predict(ins, pc, rs, rt, model_copy, um));
            model_copy = flags;
        end
    endtask
    task automatic random_mix(input string name, input int count);
        logic [31:0] ins, rs;
        int          k;
        for (int i = 0; i < count; i++) begin
            k = $random(seed) & 7;
            ins = $random(seed);
            rs = $random(seed);
            if (k < 4 || k == 7) begin
                ins[31:21] = {OPC_COPRO_PREFIX, ins[27:26], SUB_BRANCH};
                if (k < 4) ins[20:16] = 5'(k);
                else ins[20:16] = {3'h1, ins[17:16]};
            end
            if (k == 4 || k == 5) ins[31:26] = OPC_EQUAL;
            // copro kinds get a random usable mask too, biased to usable so branches still resolve
            issue((k != 6) || ins[0], ins, $random(seed) & 32'hFFFF_FFFC, rs,
                  (k == 4) ? rs : 32'($random(seed)),
                  (k < 4 || k == 5) ? 4'($random(seed)) | 4'($random(seed)) : 4'hF);
        end
        issue(1'b0, 32'h0, 32'h0, 32'h0, 32'h0, 4'hF);
        $display("test %s done", name);
    endtask
    // result watcher: one note per valid instruction, quiet pulses otherwise
    always @(posedge clk_i) begin
        obs_pending <= instr_valid_i && !rst_i;
        cycles++;
        if (cycles == 4000) begin
            err_total++;
            complete_run();
        end
    end
    always @(negedge clk_i) begin
        if (obs_pending && exp_q.size() > 0) begin
            got = exp_q.pop_front();
            `CHECK(redirect_o, got.red, "redirect pulse")
            `CHECK(nullify_slot_o, got.nul, "slot nullify")
            `CHECK(copro_unusable_o, got.unu, "unusable pulse")
            if (got.red) `CHECK(redirect_target_o, got.tgt, "branch target")
            if (got.unu) `CHECK(unusable_unit_o, got.unit, "unusable unit")
        end else if (!rst_i) begin
            `CHECK({redirect_o, nullify_slot_o, copro_unusable_o}, 3'h0, "idle pulse")
        end
    end
    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        random_mix("random_mix_fast", 300);
        slow <= 1'b1;
        random_mix("random_mix_slow", 200);
        // mid-run reset: first copro-true branch after it must see a false copy
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        exp_q.delete();
        model_copy = 4'h0;
        issue(1'b1, 32'h4501_0010, 32'h0000_1000, 32'h0, 32'h0, 4'hF);
        random_mix("reset_mid_run", 50);
        repeat (2) @(posedge clk_i);
        complete_run();
    end
endmodule // copro_and_equal_branch_unit_tb_top

// >>> tb/copro_flag_source.sv
// coprocessor condition flag source standing at the far side of the branch unit
module copro_flag_source #(
    parameter int UNITS = 4
) (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             slow_i,
    output logic      [UNITS-1:0] flags_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] shift_state;
    logic [2:0]  hold_count;
    logic        feedback;
    assign feedback = shift_state[15] ^ shift_state[13] ^ shift_state[12] ^ shift_state[10];
    // flags move just after an edge; slow mode holds them for eight cycles
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            shift_state <= 16'hACE1;
            hold_count  <= 3'h0;
        end else begin
            hold_count <= hold_count + 3'h1;
            if (!slow_i || hold_count == 3'h0) begin
                shift_state <= {shift_state[14:0], feedback};
            end
        end
    end
    assign flags_o = shift_state[UNITS-1:0];
endmodule // copro_flag_source
